// *** common/vdac_pkg.sv ***
/*
  Constants, field positions and level codes for the video converter input
  register block. Assumes a single 10 MHz system clock drives every user.
*/
package vdac_pkg;

  // ----------------------------------------------------------------------
  // Widths and buffer size
  // ----------------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 12;
  localparam int LVL_W      = 9;
  localparam int SEG_N      = 63;
  localparam int LSB_SW_N   = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;
  localparam int PIN_N      = 14;

  typedef logic [WORD_W-1:0] vdac_word_t;
  typedef logic [LVL_W-1:0]  vdac_lvl_t;

  // ----------------------------------------------------------------------
  // Captured word layout: data in [7:0], controls above
  // ----------------------------------------------------------------------
  localparam int BIT_BRIGHTEN = 8;
  localparam int BIT_FORCE    = 9;
  localparam int BIT_BLANK    = 10;
  localparam int BIT_SYNC     = 11;
  localparam int PIN_CONV     = 12;
  localparam int PIN_FEED     = 13;

  // ----------------------------------------------------------------------
  // Output levels in converter steps, sync tip is zero
  // ----------------------------------------------------------------------
  localparam vdac_lvl_t LVL_SYNC  = 9'h000;
  localparam vdac_lvl_t LVL_BLANK = 9'h071;
  localparam vdac_lvl_t LVL_BLACK = 9'h086;
  localparam vdac_lvl_t LVL_BRIGHT = 9'h01D;
  localparam vdac_lvl_t LVL_FULL  = 9'h1A2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_FULL = 8'hFF;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CONN   = 4'h8;
  localparam logic [3:0] REG_LAST   = 4'hC;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ECL = 1;
  localparam logic [1:0]        CTRL_RST = 2'h1;
  localparam logic [WORD_W-1:0] CONN_RST = 12'hFFF;
  localparam int ST_FEED     = 5;
  localparam int ST_VALID    = 6;
  localparam int ST_OVERFLOW = 7;
  localparam int ST_CAPRDY   = 8;

endpackage

// *** rtl/vdac_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module vdac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [LVL_W-1:0]      level_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [LVL_W-1:0] count_q;
  wire              push;
  wire              pop;

  // ----------------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------------
  assign in_ready_o  = (count_q != LVL_W'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_ptr_q];
  assign level_o     = count_q;

  // Storage needs no reset, only the pointers and count carry state
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers wrap naturally because depth is a power of two
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(push);
      rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
      count_q  <= count_q + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule

// *** rtl/vdac_seg_decoder.sv ***
/*
  Segment decoder: six upper bits to a thermometer code, two lower bits
  to the fine switches. Purely combinational; the caller registers it.
*/
`timescale 1ns/1ps
module vdac_seg_decoder
  import vdac_pkg::*;
(
  input  wire logic [vdac_pkg::DATA_W-1:0]   data_i,
  output logic [vdac_pkg::SEG_N-1:0]         therm_o,
  output logic [vdac_pkg::LSB_SW_N-1:0]      lsb_sw_o
);
  wire [5:0] coarse;
  wire [1:0] fine;

  assign coarse = data_i[7:2];
  assign fine   = data_i[1:0];

  // ----------------------------------------------------------------------
  // Thermometer: segment i is on when the coarse value exceeds i
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < SEG_N; i++) begin : g_seg
    assign therm_o[i] = (coarse > 6'(i));
  end

  // Fine switches as two complementary pairs, weight one then weight two
  assign lsb_sw_o = {~fine[1], fine[1], ~fine[0], fine[0]};
endmodule

// *** rtl/vdac_input_reg.sv ***
/*
  Digital front end of an 8-bit video converter: pin capture on the
  convert clock or feedthrough, 16-word buffer, video level priority,
  segment decode and complementary level codes, plus a small register port.
  Assumes pins arrive asynchronous to CLK_SYS_I and are slower than it.
*/
`timescale 1ns/1ps
module vdac_input_reg
  import vdac_pkg::*;
(
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         SYS_RST_I,
  input  wire logic [vdac_pkg::DATA_W-1:0]  DATA_I,
  input  wire logic                         SYNC_I,
  input  wire logic                         BLANK_I,
  input  wire logic                         FORCE_FULL_SCALE_I,
  input  wire logic                         BRIGHTEN_OFFSET_I,
  input  wire logic                         CONV_I,
  input  wire logic                         FEEDTHROUGH_SELECT_I,
  input  wire logic [3:0]                   REG_ADDR_I,
  input  wire logic [31:0]                  REG_WDATA_I,
  input  wire logic                         REG_WR_I,
  input  wire logic                         REG_RD_I,
  output logic [31:0]                       REG_RDATA_O,
  output logic [vdac_pkg::LVL_W-1:0]        OUT_POS_O,
  output logic [vdac_pkg::LVL_W-1:0]        OUT_NEG_O,
  output logic [vdac_pkg::SEG_N-1:0]        THERM_O,
  output logic [vdac_pkg::LSB_SW_N-1:0]     LSB_SW_O,
  output logic                              OUT_VALID_O,
  output logic                              CAP_READY_O
);
  import vdac_pkg::*;

  // ----------------------------------------------------------------------
  // Level selection, shared by the output path and the checks
  // ----------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] eff_data(input vdac_word_t w);
    if (w[BIT_SYNC] || w[BIT_BLANK]) begin
      return DATA_ZERO;
    end else if (w[BIT_FORCE]) begin
      return DATA_FULL;
    end
    return w[DATA_W-1:0];
  endfunction

  function automatic vdac_lvl_t level_of(input vdac_word_t w);
    vdac_lvl_t base;
    base = LVL_BLACK + LVL_W'(eff_data(w));
    if (w[BIT_SYNC]) begin
      return LVL_SYNC;
    end else if (w[BIT_BLANK]) begin
      return LVL_BLANK;
    end else if (w[BIT_BRIGHTEN]) begin
      return base + LVL_BRIGHT;
    end
    return base;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [PIN_N-1:0]  pin_s1_q;
  logic [PIN_N-1:0]  pin_s2_q;
  logic              conv_prev_q;
  wire  [PIN_N-1:0]  pin_raw;

  assign pin_raw = {FEEDTHROUGH_SELECT_I, CONV_I, SYNC_I, BLANK_I,
                    FORCE_FULL_SCALE_I, BRIGHTEN_OFFSET_I, DATA_I};

  // Two stages; only the second stage feeds any logic
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_s1_q    <= '0;
      pin_s2_q    <= '0;
      conv_prev_q <= 1'b0;
    end else begin
      pin_s1_q    <= pin_raw;
      pin_s2_q    <= pin_s1_q;
      conv_prev_q <= pin_s2_q[PIN_CONV];
    end
  end

  // ----------------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------------
  logic [1:0]   ctrl_q;
  vdac_word_t   conn_q;
  logic         ovf_q;
  vdac_word_t   last_q;
  wire          wr_ctrl;
  wire          wr_conn;
  wire          wr_status;
  wire          run;
  wire          ecl;

  assign wr_ctrl   = REG_WR_I && (REG_ADDR_I == REG_CTRL);
  assign wr_conn   = REG_WR_I && (REG_ADDR_I == REG_CONN);
  assign wr_status = REG_WR_I && (REG_ADDR_I == REG_STATUS);
  assign run       = ctrl_q[CTRL_RUN];
  assign ecl       = ctrl_q[CTRL_ECL];

  // Control and connection mask
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= CTRL_RST;
      conn_q <= CONN_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= REG_WDATA_I[1:0];
      if (wr_conn) conn_q <= REG_WDATA_I[WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Capture decode
  // ----------------------------------------------------------------------
  wire         feed_sel;
  wire         conv_rise;
  wire         cap_req;
  wire         cap_ready;
  vdac_word_t  pin_mask;
  vdac_word_t  word_in;

  assign feed_sel  = pin_s2_q[PIN_FEED];
  assign conv_rise = pin_s2_q[PIN_CONV] && !conv_prev_q;
  // A floating emitter-coupled pin is pulled low; software names which are wired
  assign pin_mask  = ecl ? conn_q : CONN_RST;
  assign word_in   = pin_s2_q[WORD_W-1:0] & pin_mask;
  // Data and controls travel in one word, so they stay on the same edge
  assign cap_req   = conv_rise && !feed_sel;

  // Overflow sticky: a new loss wins over a write-one clear
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ovf_q <= 1'b0;
    end else if (cap_req && !cap_ready) begin
      ovf_q <= 1'b1;
    end else if (wr_status && REG_WDATA_I[ST_OVERFLOW]) begin
      ovf_q <= 1'b0;
    end
  end

  // Last accepted capture, visible to software
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_q <= '0;
    end else if (cap_req && cap_ready) begin
      last_q <= word_in;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer between capture and output; run low stalls the drain
  // ----------------------------------------------------------------------
  vdac_word_t             fifo_out;
  wire                    fifo_valid;
  wire                    pop;
  wire [FIFO_LVL_W-1:0]   fifo_level;

  assign pop = fifo_valid && run && !feed_sel;

  vdac_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .LVL_W (FIFO_LVL_W)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (word_in),
    .in_valid_i  (cap_req),
    .in_ready_o  (cap_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .level_o     (fifo_level)
  );

  // ----------------------------------------------------------------------
  // Current word: feedthrough tracks the pins every cycle
  // ----------------------------------------------------------------------
  vdac_word_t  cur_q;
  logic        cur_valid_q;
  wire         cur_load;
  vdac_word_t  cur_d;

  assign cur_load = feed_sel || pop;
  assign cur_d    = feed_sel ? word_in : fifo_out;

  // Reset clears the word only for determinism; validity marks real data
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cur_q       <= '0;
      cur_valid_q <= 1'b0;
    end else if (cur_load) begin
      cur_q       <= cur_d;
      cur_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  vdac_lvl_t                 lvl;
  wire [SEG_N-1:0]           therm;
  wire [LSB_SW_N-1:0]        lsb_sw;

  assign lvl = level_of(cur_q);

  vdac_seg_decoder u_dec (
    .data_i   (eff_data(cur_q)),
    .therm_o  (therm),
    .lsb_sw_o (lsb_sw)
  );

  // Both sinks come from one level so they can never disagree
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      OUT_POS_O   <= '0;
      OUT_NEG_O   <= '0;
      THERM_O     <= '0;
      LSB_SW_O    <= '0;
      OUT_VALID_O <= 1'b0;
      CAP_READY_O <= 1'b0;
    end else begin
      OUT_POS_O   <= lvl;
      OUT_NEG_O   <= LVL_FULL - lvl;
      THERM_O     <= therm;
      LSB_SW_O    <= lsb_sw;
      OUT_VALID_O <= cur_valid_q;
      CAP_READY_O <= cap_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (REG_ADDR_I)
      REG_CTRL:   rd_mux[1:0] = ctrl_q;
      REG_STATUS: rd_mux[ST_CAPRDY:0] = {cap_ready, ovf_q, cur_valid_q, feed_sel, fifo_level};
      REG_CONN:   rd_mux[WORD_W-1:0] = conn_q;
      REG_LAST:   rd_mux[WORD_W-1:0] = last_q;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Unmapped reads return zero; a cycle without a read shows zero too
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else begin
      REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  property p_capture;
    cap_req && cap_ready |=> last_q == $past(word_in);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost word");

  property p_feedthrough;
    feed_sel |=> cur_q == $past(word_in) ##1 OUT_POS_O == $past(lvl);
  endproperty
  a_feedthrough: assert property (p_feedthrough) else $error("feedthrough not tracking");

  // Buffer and last capture stay frozen while the pins pass straight through
  property p_feed_frozen;
    feed_sel |=> $stable(fifo_level) && $stable(last_q);
  endproperty
  a_feed_frozen: assert property (p_feed_frozen) else $error("capture during feedthrough");

  property p_therm;
    OUT_VALID_O |-> $countones(THERM_O) == int'(($past(eff_data(cur_q)) >> 2));
  endproperty
  a_therm: assert property (p_therm) else $error("thermometer count wrong");

  property p_sync;
    cur_q[BIT_SYNC] |=> OUT_POS_O == LVL_SYNC && THERM_O == '0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync level wrong");

  property p_blank;
    !cur_q[BIT_SYNC] && cur_q[BIT_BLANK] |=> OUT_POS_O == LVL_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("blank level wrong");

  property p_force;
    cur_q[BIT_FORCE] && !cur_q[BIT_BRIGHTEN] && !cur_q[BIT_SYNC] && !cur_q[BIT_BLANK]
      |=> OUT_POS_O == LVL_BLACK + 9'h0FF;
  endproperty
  a_force: assert property (p_force) else $error("white level wrong");

  property p_bright;
    cur_q[BIT_BRIGHTEN] && !cur_q[BIT_SYNC] && !cur_q[BIT_BLANK]
      |=> OUT_POS_O == LVL_BLACK + LVL_W'($past(eff_data(cur_q))) + LVL_BRIGHT;
  endproperty
  a_bright: assert property (p_bright) else $error("brighten offset wrong");

  property p_pulldown;
    ecl |-> (word_in & ~conn_q) == '0;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("open pin not low");

  property p_compl;
    OUT_VALID_O |-> OUT_POS_O + OUT_NEG_O == LVL_FULL;
  endproperty
  a_compl: assert property (p_compl) else $error("outputs not complementary");

  property p_valid_hold;
    OUT_VALID_O |=> OUT_VALID_O;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");

  c_capture:  cover property (cap_req && cap_ready ##2 OUT_VALID_O);
  c_full:     cover property (cap_req && !cap_ready);
  c_feed:     cover property (feed_sel ##2 OUT_VALID_O);
  c_bright:   cover property (OUT_POS_O == LVL_FULL);
endmodule

// *** test/vdac_pix_src.sv ***
/*
  Pixel source model: drives data, video controls, convert clock and
  feedthrough select. Assumes the bench clock paces every change.
*/
`timescale 1ns/1ps
module vdac_pix_src
  import vdac_pkg::*;
(
  input  wire logic                   clk_i,
  output logic [vdac_pkg::DATA_W-1:0] data_o,
  output logic                        sync_o,
  output logic                        blank_o,
  output logic                        force_o,
  output logic                        bright_o,
  output logic                        conv_o,
  output logic                        feed_o
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Idle pins at time zero; select low means capture mode
  initial begin
    {sync_o, blank_o, force_o, bright_o, data_o} <= '0;
    conv_o <= 1'b0;
    feed_o <= 1'b0;
  end

  // Present a word on the pins with no convert edge
  task automatic put(input vdac_word_t w);
    @(posedge clk_i);
    {sync_o, blank_o, force_o, bright_o, data_o} <= w;
  endtask

  // Pins settle before the edge and hold after it; pulses are long
  // because the pins are sampled by the system clock
  task automatic send(input vdac_word_t w);
    put(w);
    repeat (3) @(posedge clk_i);
    conv_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    conv_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Select moves only between frames, then stays static
  task automatic set_feed(input logic b);
    @(posedge clk_i);
    feed_o <= b;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** test/tb_top.sv ***
/*
  Self-checking bench for the converter input register.
  Assumes the pixel source model drives every pin input.
*/
`timescale 1ns/1ps
module tb_top;
  import vdac_pkg::*;
  // ----------------------------------------------------------------
  // Clock, reset and instances
  // ----------------------------------------------------------------
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [DATA_W-1:0]   data;
  logic                sync, blank, force_fs, bright, conv, feed;
  logic [3:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  logic [LVL_W-1:0]    out_pos, out_neg;
  logic [SEG_N-1:0]    therm;
  logic [LSB_SW_N-1:0] lsb_sw;
  logic                out_valid, cap_ready;
  int                  n_mismatch = 0;
  int                  checks_done = 0;
  localparam logic [31:0] ST_V = 32'h1 << ST_VALID;
  localparam logic [31:0] ST_R = 32'h1 << ST_CAPRDY;
  localparam vdac_word_t TBL [12] = '{12'h000, 12'h0FF, 12'h055, 12'h0AA,
    12'h1C0, 12'h2AB, 12'h333, 12'h1FF, 12'h4FF, 12'h7FF, 12'h800, 12'hFFF};

  // 100 ns period
  always #50 clk = ~clk;

  vdac_pix_src i_vdac_pix_src (.clk_i(clk), .data_o(data), .sync_o(sync),
    .blank_o(blank), .force_o(force_fs), .bright_o(bright), .conv_o(conv), .feed_o(feed));

  vdac_input_reg i_vdac_input_reg (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .DATA_I(data), .SYNC_I(sync), .BLANK_I(blank), .FORCE_FULL_SCALE_I(force_fs),
    .BRIGHTEN_OFFSET_I(bright), .CONV_I(conv), .FEEDTHROUGH_SELECT_I(feed),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .OUT_POS_O(out_pos),
    .OUT_NEG_O(out_neg), .THERM_O(therm), .LSB_SW_O(lsb_sw),
    .OUT_VALID_O(out_valid), .CAP_READY_O(cap_ready));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  // Every comparison is counted; unknowns never match
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_cmp(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp(reg_rdata, exp);
  endtask

  // Expected level in steps: sync, blank, then force, plus brighten
  function automatic vdac_lvl_t lvl_of(input vdac_word_t w);
    logic [DATA_W-1:0] d;
    d = w[BIT_FORCE] ? DATA_FULL : w[DATA_W-1:0];
    if (w[BIT_SYNC])
      return LVL_SYNC;
    if (w[BIT_BLANK])
      return LVL_BLANK;
    return LVL_BLACK + {1'b0, d} + (w[BIT_BRIGHTEN] ? LVL_BRIGHT : '0);
  endfunction

  // Judge the level, switch and valid outputs against the word; sampled mid-cycle
  task automatic check_out(input vdac_word_t w);
    logic [DATA_W-1:0] d;
    vdac_lvl_t         l;
    d = w[BIT_FORCE] ? DATA_FULL : w[DATA_W-1:0];
    l = lvl_of(w);
    @(negedge clk);
    cmp(32'(out_pos), 32'(l));
    cmp(32'(out_neg), 32'(LVL_FULL - l));
    cmp(32'(out_valid), 32'h1);
    if (w[BIT_SYNC] | w[BIT_BLANK]) begin
      cmp(32'($countones(therm)), 32'h0);
    end else begin
      cmp(32'($countones(therm)), 32'(d >> 2));
      cmp(32'(lsb_sw), {28'h0, ~d[1], d[1], ~d[0], d[0]});
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Register defaults, unmapped place, no output before a capture
  task automatic t_reset;
    @(negedge clk);
    cmp(32'(out_valid), 32'h0);
    rd_cmp(REG_CTRL, 32'(CTRL_RST));
    rd_cmp(REG_CONN, 32'(CONN_RST));
    rd_cmp(REG_STATUS, ST_R);
    reg_wr_t(4'h2, 32'hFFFF_FFFF);
    rd_cmp(4'h2, 32'h0);
    rd_cmp(REG_CTRL, 32'(CTRL_RST));
    $display("TB: test reset done");
  endtask

  // Eight of the sixteen control combinations, back to back captures
  task automatic t_levels;
    foreach (TBL[i]) begin
      i_vdac_pix_src.send(TBL[i]);
      check_out(TBL[i]);
      rd_cmp(REG_LAST, 32'(TBL[i]));
    end
    $display("TB: test levels done");
  endtask

  // Pins pass straight through, then freeze again once select drops
  task automatic t_feedthrough;
    i_vdac_pix_src.set_feed(1'b1);
    rd_cmp(REG_STATUS, (32'h1 << ST_FEED) | ST_V | ST_R);
    i_vdac_pix_src.put(12'h16C);
    repeat (6) @(posedge clk);
    check_out(12'h16C);
    i_vdac_pix_src.put(12'h40A);
    repeat (6) @(posedge clk);
    check_out(12'h40A);
    i_vdac_pix_src.set_feed(1'b0);
    i_vdac_pix_src.put(12'h0E1);
    repeat (6) @(posedge clk);
    check_out(12'h40A);
    i_vdac_pix_src.send(12'h0E1);
    check_out(12'h0E1);
    $display("TB: test feedthrough done");
  endtask

  // Open pins read low only on the emitter-coupled variant
  task automatic t_ecl;
    reg_wr_t(REG_CONN, 32'h077F);
    i_vdac_pix_src.send(12'h8FF);
    check_out(12'h8FF);
    reg_wr_t(REG_CTRL, 32'h3);
    i_vdac_pix_src.send(12'h8FF);
    check_out(12'h07F);
    rd_cmp(REG_LAST, 32'h07F);
    reg_wr_t(REG_CTRL, 32'(CTRL_RST));
    reg_wr_t(REG_CONN, 32'(CONN_RST));
    $display("TB: test ecl done");
  endtask

  // Stall the drain, overfill by one, clear the flag, then drain
  task automatic t_buffer;
    reg_wr_t(REG_CTRL, 32'h0);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      i_vdac_pix_src.send(12'h020 + 12'(i));
    end
    @(negedge clk);
    cmp(32'(cap_ready), 32'h0);
    rd_cmp(REG_STATUS, 32'(FIFO_DEPTH) | ST_V | (32'h1 << ST_OVERFLOW));
    reg_wr_t(REG_STATUS, 32'h1 << ST_OVERFLOW);
    rd_cmp(REG_STATUS, 32'(FIFO_DEPTH) | ST_V);
    reg_wr_t(REG_CTRL, 32'(CTRL_RST));
    repeat (40) @(posedge clk);
    check_out(12'h020 + 12'(FIFO_DEPTH - 1));
    rd_cmp(REG_STATUS, ST_V | ST_R);
    $display("TB: test buffer done");
  endtask

  // Reset in mid-run: outputs drop to zero, registers to defaults, capture resumes
  task automatic t_mid_reset;
    reg_wr_t(REG_CONN, 32'h0000_0123);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp(32'(out_valid), 32'h0);
    cmp(32'(out_pos), 32'h0);
    cmp(32'(out_neg), 32'h0);
    repeat (3) @(posedge clk);
    rd_cmp(REG_CONN, 32'(CONN_RST));
    rd_cmp(REG_STATUS, ST_R);
    i_vdac_pix_src.send(12'h0C3);
    check_out(12'h0C3);
    $display("TB: test mid reset done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("TB: checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Reset 12 cycles, then let the pin synchronisers settle
  initial begin
    reg_addr  <= 4'h0;
    reg_wdata <= 32'h0000_0000;
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_levels;
    t_feedthrough;
    t_ecl;
    t_buffer;
    t_mid_reset;
    tally_and_finish;
  end

  // Tests need under six hundred cycles; ten thousand means a hang
  initial begin
    #1_000_000;
    n_mismatch++;
    $display("TB: watchdog expired");
    tally_and_finish;
  end
endmodule
